/* logic/terminal_decoder_pkg.sv */
// Purpose: Shared constants for the input terminal function decoder.
// Assumes: 25 MHz control clock, Avalon-MM register access.
// Notes:   Byte offsets are word aligned; unmapped reads return zero.
package terminal_decoder_pkg;
	// Clock and timing
	localparam int CLOCK_HZ         = 25_000_000;   // Control clock rate
	localparam int HOLD_LIMIT_SEC   = 4;            // Reset input hold time before error
	localparam int HOLD_LIMIT_CYC   = HOLD_LIMIT_SEC * CLOCK_HZ;
	localparam int TENTH_SEC_MS     = 100;          // Ramp time unit in ms
	localparam int TENTH_SEC_CYC    = (TENTH_SEC_MS * (CLOCK_HZ / 1000));

	// Terminal function codes
	localparam logic [4:0] FN_ANALOG_SELECT = 5'h0D; // Current/voltage select
	localparam logic [4:0] FN_FAULT_RESET   = 5'h0E; // Fault reset
	localparam logic [4:0] FN_THREE_START   = 5'h0F; // Three-wire start
	localparam logic [4:0] FN_THREE_KEEP    = 5'h10; // Three-wire keep
	localparam logic [4:0] FN_THREE_DIR     = 5'h11; // Three-wire direction
	localparam logic [4:0] FN_UP            = 5'h12; // Raise reference
	localparam logic [4:0] FN_DOWN          = 5'h13; // Lower reference
	localparam logic [4:0] FN_KEYPAD_OVR    = 5'h14; // Keypad override
	localparam logic [4:0] FN_TERMINAL_OVR  = 5'h15; // Terminal override
	localparam logic [4:0] FN_INTEGRAL_CLR  = 5'h16; // Integral clear
	localparam logic [4:0] FN_PID_BYPASS    = 5'h17; // PID bypass

	// Setting encodings
	localparam logic [1:0] FREQ_SRC_TERMINAL = 2'h1; // Frequency from terminals
	localparam logic [1:0] PID_MODE_PID      = 2'h1; // PID control
	localparam logic [1:0] PID_MODE_FEED     = 2'h2; // Feed-forward control
	localparam logic [7:0] COMM_ERROR_CODE   = 8'h3C; // Error number 60

	// Command source selection
	typedef enum logic [1:0] {
		SRC_CONFIGURED = 2'b00,
		SRC_KEYPAD     = 2'b01,
		SRC_TERMINAL   = 2'b10
	} cmd_source_t;

	// Register byte offsets
	localparam logic [7:0] ADDR_FUNC_BASE    = 8'h00; // Function code, 4 bytes per terminal
	localparam logic [7:0] ADDR_POLARITY     = 8'h20;
	localparam logic [7:0] ADDR_FREQ_SOURCE  = 8'h24;
	localparam logic [7:0] ADDR_RUN_SOURCE   = 8'h28;
	localparam logic [7:0] ADDR_PID_MODE     = 8'h2C;
	localparam logic [7:0] ADDR_MAX_FREQ     = 8'h30;
	localparam logic [7:0] ADDR_SAVE_ENABLE  = 8'h34;
	localparam logic [7:0] ADDR_INITIAL      = 8'h38;
	localparam logic [7:0] ADDR_RAMP_TIME    = 8'h3C;
	localparam logic [7:0] ADDR_STATUS       = 8'h40;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h44;
	localparam logic [7:0] ADDR_IRQ_MASK     = 8'h48;
	localparam logic [7:0] ADDR_UPDOWN_REF   = 8'h4C;

	// Reset values
	localparam logic [4:0]  FUNC_RESET      = 5'h1F; // Unassigned code
	localparam logic [15:0] MAX_FREQ_RESET  = 16'h1770; // 60.00 Hz
	localparam logic [15:0] RAMP_RESET      = 16'h0064; // 10.0 s

	// Interrupt bit positions
	localparam int IRQ_FAULT_CLEARED = 0;
	localparam int IRQ_COMM_ERROR    = 1;
	localparam int IRQ_OVERRIDE_STOP = 2;
	localparam int IRQ_BITS          = 3;
endpackage : terminal_decoder_pkg

/* logic/terminal_decoder.sv */
// Purpose: Decode programmable input terminals into drive control actions.
// Assumes: Terminal inputs synchronous and debounced; one clock.
// Notes:   Registers over Avalon-MM; one wait state per access.
// Functional notes
// (R1) Code 13: shorted picks current, open voltage
// (R2) No select terminal: sum voltage and current; code sums only with terminal frequency source, else voltage alone
// (R3) Code 14 active clears active fault
// (R4) Reset held over 4 s flags error
// (R5) Operator removes run before fault reset
// (R6) Codes 15-17: start, keep, direction
// (R7) Codes 18/19 raise or lower reference
// (R8) Save setting keeps initial value over power
// (R9) Initial value loaded at next run start
// (R10) Ramp time sets up/down rate
// (R11) Codes 20/21 select keypad or terminal source
// (R12) Keypad override beats terminal override
// (R13) Source change while running stops first
// (R14) Code 22 forces integral term reset
// (R15) PID functions only in modes 1, 2
// (R16) Code 23 bypasses PID control
// (R17) Polarity 0 means normally open
// (R18) Up/down reference saturates, never wraps
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module terminal_decoder
	import terminal_decoder_pkg::*;
#(
	parameter int NUM_TERMINALS = 6,                // Input terminal count
	parameter int HOLD_CYCLES   = HOLD_LIMIT_CYC,  // Reset hold limit
	parameter int TENTH_CYCLES  = TENTH_SEC_CYC    // Cycles per 0.1 s
) (
	input  wire logic                     i_clock,          // Control clock
	input  wire logic                     i_reset,          // Synchronous reset
	input  wire logic [7:0]               i_address,        // Avalon byte address
	input  wire logic                     i_read,           // Avalon read
	input  wire logic                     i_write,          // Avalon write
	input  wire logic [31:0]              i_writedata,      // Avalon write data
	output logic      [31:0]              o_readdata,       // Avalon read data
	output logic                          o_waitrequest,    // Avalon wait
	input  wire logic [NUM_TERMINALS-1:0] i_terminal,       // Raw terminal levels
	input  wire logic [15:0]              i_voltage_value,  // Voltage input freq
	input  wire logic [15:0]              i_current_value,  // Current input freq
	input  wire logic                     i_fault_active,   // Drive in fault
	input  wire logic                     i_stop_reset_key, // Stop/reset key
	input  wire logic                     i_run_command,    // Run from any source
	input  wire logic                     i_running,        // Drive is running
	output logic                          o_use_current,    // Current input chosen
	output logic      [15:0]              o_analog_freq,    // Analog freq value
	output logic                          o_fault_clear,    // Fault clear pulse
	output logic                          o_comm_error,     // Error 60 shown
	output logic                          o_three_wire_run, // Three-wire run
	output logic                          o_reverse,        // Direction reverse
	output logic      [15:0]              o_updown_freq,    // Up/down reference
	output logic      [1:0]               o_cmd_source,     // Active source
	output logic                          o_override_stop,  // Stop for source change
	output logic                          o_integral_clear, // PID integral reset
	output logic                          o_pid_bypass,     // PID bypassed
	output logic                          o_irq             // Interrupt level
);

	// Settings
	logic [4:0]               term_func [NUM_TERMINALS]; // Function per terminal
	logic [NUM_TERMINALS-1:0] terminal_polarity;         // 1 = normally closed
	logic [1:0]               freq_command_source;       // Frequency source
	logic [1:0]               run_command_source;        // Run source
	logic [1:0]               pid_mode_select;           // PID mode
	logic [15:0]              max_frequency;             // 0.01 Hz units
	logic                     updown_save_enable;        // Keep initial value
	logic [15:0]              updown_initial_value;      // 0.01 Hz units
	logic [15:0]              updown_ramp_time;          // 0.1 s units
	logic [IRQ_BITS-1:0]      irq_status;                // Sticky events
	logic [IRQ_BITS-1:0]      irq_mask;                  // Event enables

	// Decode state
	logic [NUM_TERMINALS-1:0] term_active;   // Function asserted per terminal
	logic [31:0]              fn_assigned;   // Any terminal holds code
	logic [31:0]              fn_active;     // Any active terminal holds code
	logic                     reset_prev;    // Fault reset last cycle
	logic [31:0]              hold_count;    // Fault reset hold time
	logic                     run_prev;      // Run command last cycle
	logic [39:0]              ramp_acc;      // Rate accumulator
	logic [39:0]              ramp_limit;    // Cycles for full range
	logic [39:0]              next_acc;      // Accumulator plus step
	logic [1:0]               next_source;   // Requested command source
	logic                     pid_enabled;   // PID mode 1 or 2
	logic                     bus_go;        // Access completes now
	logic [IRQ_BITS-1:0]      irq_event;     // Event pulses this cycle

	// Per-terminal polarity
	generate
		for (genvar t = 0; t < NUM_TERMINALS; t++) begin : g_term
			assign term_active[t] = i_terminal[t] ^ terminal_polarity[t]; // R17
		end
	endgenerate

	// Which function codes are assigned and which asserted
	always_comb begin
		fn_assigned = 32'h0;
		fn_active   = 32'h0;
		for (int t = 0; t < NUM_TERMINALS; t++) begin
			fn_assigned[term_func[t]] = 1'b1;
			if (term_active[t]) begin
				fn_active[term_func[t]] = 1'b1;
			end
		end
	end

	// Source priority and PID enable
	always_comb begin
		if (fn_active[FN_KEYPAD_OVR]) begin
			next_source = SRC_KEYPAD; // R11 R12
		end else if (fn_active[FN_TERMINAL_OVR]) begin
			next_source = SRC_TERMINAL; // R11
		end else begin
			next_source = SRC_CONFIGURED;
		end
		pid_enabled = (pid_mode_select == PID_MODE_PID) || (pid_mode_select == PID_MODE_FEED); // R15
	end

	// Ramp arithmetic; zero ramp time treated as one unit
	always_comb begin
		ramp_limit = 40'(updown_ramp_time == 16'h0 ? 16'h1 : updown_ramp_time) * 40'(TENTH_CYCLES); // R10
		next_acc   = ramp_acc + 40'(max_frequency);
	end

	assign bus_go = (i_read || i_write) && !o_waitrequest;

	// Bus handshake: one wait cycle then completion
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_waitrequest <= 1'b1;
		end else if (bus_go) begin
			o_waitrequest <= 1'b1; // Completed, back to waiting
		end else if (i_read || i_write) begin
			o_waitrequest <= 1'b0; // Answer next edge
		end else begin
			o_waitrequest <= 1'b1;
		end
	end

	// Read data, captured with the answer
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_readdata <= 32'h0;
		end else if (i_read && o_waitrequest) begin
			o_readdata <= 32'h0; // Unmapped default
			for (int t = 0; t < NUM_TERMINALS; t++) begin
				if (i_address == ADDR_FUNC_BASE + 8'(t * 4)) begin
					o_readdata <= {27'h0, term_func[t]};
				end
			end
			if (i_address == ADDR_POLARITY) begin
				o_readdata <= 32'(terminal_polarity);
			end else if (i_address == ADDR_FREQ_SOURCE) begin
				o_readdata <= {30'h0, freq_command_source};
			end else if (i_address == ADDR_RUN_SOURCE) begin
				o_readdata <= {30'h0, run_command_source};
			end else if (i_address == ADDR_PID_MODE) begin
				o_readdata <= {30'h0, pid_mode_select};
			end else if (i_address == ADDR_MAX_FREQ) begin
				o_readdata <= {16'h0, max_frequency};
			end else if (i_address == ADDR_SAVE_ENABLE) begin
				o_readdata <= {31'h0, updown_save_enable};
			end else if (i_address == ADDR_INITIAL) begin
				o_readdata <= {16'h0, updown_initial_value};
			end else if (i_address == ADDR_RAMP_TIME) begin
				o_readdata <= {16'h0, updown_ramp_time};
			end else if (i_address == ADDR_STATUS) begin
				o_readdata <= {8'h0, o_comm_error ? COMM_ERROR_CODE : 8'h0, 6'h0, o_cmd_source,
					o_pid_bypass, o_integral_clear, o_override_stop, o_reverse,
					o_three_wire_run, o_comm_error, o_fault_clear, o_use_current};
			end else if (i_address == ADDR_IRQ_STATUS) begin
				o_readdata <= 32'(irq_status);
			end else if (i_address == ADDR_IRQ_MASK) begin
				o_readdata <= 32'(irq_mask);
			end else if (i_address == ADDR_UPDOWN_REF) begin
				o_readdata <= {16'h0, o_updown_freq};
			end
		end
	end

	// Setting registers written by software
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			for (int t = 0; t < NUM_TERMINALS; t++) begin
				term_func[t] <= FUNC_RESET;
			end
			terminal_polarity   <= '0;
			freq_command_source <= 2'h0;
			run_command_source  <= 2'h0;
			pid_mode_select     <= 2'h0;
			max_frequency       <= MAX_FREQ_RESET;
			updown_save_enable  <= 1'b0;
			updown_ramp_time    <= RAMP_RESET;
			irq_mask            <= '0;
		end else if (bus_go && i_write) begin
			for (int t = 0; t < NUM_TERMINALS; t++) begin
				if (i_address == ADDR_FUNC_BASE + 8'(t * 4)) begin
					term_func[t] <= i_writedata[4:0];
				end
			end
			if (i_address == ADDR_POLARITY) begin
				terminal_polarity <= i_writedata[NUM_TERMINALS-1:0];
			end else if (i_address == ADDR_FREQ_SOURCE) begin
				freq_command_source <= i_writedata[1:0];
			end else if (i_address == ADDR_RUN_SOURCE) begin
				run_command_source <= i_writedata[1:0];
			end else if (i_address == ADDR_PID_MODE) begin
				pid_mode_select <= i_writedata[1:0];
			end else if (i_address == ADDR_MAX_FREQ) begin
				max_frequency <= i_writedata[15:0];
			end else if (i_address == ADDR_SAVE_ENABLE) begin
				updown_save_enable <= i_writedata[0]; // R8
			end else if (i_address == ADDR_RAMP_TIME) begin
				updown_ramp_time <= i_writedata[15:0]; // R10
			end else if (i_address == ADDR_IRQ_MASK) begin
				irq_mask <= i_writedata[IRQ_BITS-1:0];
			end
		end
	end

	// Initial value: software write, or saved reference at stop
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			updown_initial_value <= 16'h0;
		end else if (bus_go && i_write && i_address == ADDR_INITIAL) begin
			if (i_writedata[15:0] > max_frequency) begin
				updown_initial_value <= max_frequency; // R9
			end else begin
				updown_initial_value <= i_writedata[15:0];
			end
		end else if (run_prev && !i_run_command && updown_save_enable) begin
			updown_initial_value <= o_updown_freq; // R8
		end
	end

	// Analog source select
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_use_current <= 1'b0;
			o_analog_freq <= 16'h0;
		end else if (fn_assigned[FN_ANALOG_SELECT]) begin
			o_use_current <= fn_active[FN_ANALOG_SELECT]; // R1
			o_analog_freq <= fn_active[FN_ANALOG_SELECT] ? i_current_value : i_voltage_value; // R1
		end else if (freq_command_source == FREQ_SRC_TERMINAL) begin
			o_use_current <= 1'b0;
			o_analog_freq <= i_voltage_value + i_current_value; // R2
		end else begin
			o_use_current <= 1'b0;
			o_analog_freq <= i_voltage_value;
		end
	end

	// Fault reset edge and hold timer
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			reset_prev    <= 1'b0;
			hold_count    <= 32'h0;
			o_fault_clear <= 1'b0;
			o_comm_error  <= 1'b0;
		end else begin
			reset_prev    <= fn_active[FN_FAULT_RESET];
			// Operator keeps run off before reset; restart is not blocked here
			o_fault_clear <= fn_active[FN_FAULT_RESET] && !reset_prev && i_fault_active; // R3 R5
			if (!fn_active[FN_FAULT_RESET]) begin
				hold_count <= 32'h0;
			end else if (hold_count < 32'(HOLD_CYCLES)) begin
				hold_count <= hold_count + 32'h1;
			end
			if (!fn_active[FN_FAULT_RESET] || i_stop_reset_key) begin
				o_comm_error <= 1'b0; // R4
			end else if (hold_count == 32'(HOLD_CYCLES - 1)) begin
				o_comm_error <= 1'b1; // R4
			end
		end
	end

	// Three-wire run latch and direction
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_three_wire_run <= 1'b0;
			o_reverse        <= 1'b0;
		end else begin
			o_reverse <= fn_active[FN_THREE_DIR]; // R6
			if (!fn_active[FN_THREE_KEEP] || o_override_stop) begin
				o_three_wire_run <= 1'b0; // R6
			end else if (fn_active[FN_THREE_START]) begin
				o_three_wire_run <= 1'b1; // R6
			end
		end
	end

	// Up/down reference with rate accumulator
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			run_prev      <= 1'b0;
			ramp_acc      <= 40'h0;
			o_updown_freq <= 16'h0;
		end else begin
			run_prev <= i_run_command;
			if (i_run_command && !run_prev) begin
				o_updown_freq <= updown_initial_value; // R9
				ramp_acc      <= 40'h0;
			end else if (fn_active[FN_UP] != fn_active[FN_DOWN]) begin
				if (next_acc >= ramp_limit) begin
					ramp_acc <= next_acc - ramp_limit; // R10
					if (fn_active[FN_UP] && o_updown_freq < max_frequency) begin
						o_updown_freq <= o_updown_freq + 16'h1; // R7 R18
					end else if (fn_active[FN_DOWN] && o_updown_freq != 16'h0) begin
						o_updown_freq <= o_updown_freq - 16'h1; // R7 R18
					end
				end else begin
					ramp_acc <= next_acc;
				end
			end else begin
				ramp_acc <= 40'h0;
			end
			if (o_updown_freq > max_frequency) begin
				o_updown_freq <= max_frequency; // R18
			end
		end
	end

	// Command source switch, stopping the drive first
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_cmd_source    <= SRC_CONFIGURED;
			o_override_stop <= 1'b0;
		end else if (next_source != o_cmd_source) begin
			if (i_running) begin
				o_override_stop <= 1'b1; // R13
			end else begin
				o_cmd_source    <= next_source; // R11 R13
				o_override_stop <= 1'b0;
			end
		end else begin
			o_override_stop <= 1'b0;
		end
	end

	// PID terminal functions
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_integral_clear <= 1'b0;
			o_pid_bypass     <= 1'b0;
		end else begin
			o_integral_clear <= pid_enabled && fn_active[FN_INTEGRAL_CLR]; // R14 R15
			o_pid_bypass     <= pid_enabled && fn_active[FN_PID_BYPASS]; // R15 R16
		end
	end

	// Interrupt events
	always_comb begin
		irq_event                    = '0;
		irq_event[IRQ_FAULT_CLEARED] = fn_active[FN_FAULT_RESET] && !reset_prev && i_fault_active;
		irq_event[IRQ_COMM_ERROR]    = fn_active[FN_FAULT_RESET] && !i_stop_reset_key
			&& hold_count == 32'(HOLD_CYCLES - 1);
		irq_event[IRQ_OVERRIDE_STOP] = (next_source != o_cmd_source) && i_running && !o_override_stop;
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_status <= '0;
			o_irq      <= 1'b0;
		end else begin
			if (bus_go && i_write && i_address == ADDR_IRQ_STATUS) begin
				irq_status <= (irq_status & ~i_writedata[IRQ_BITS-1:0]) | irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
			o_irq <= |(irq_status & irq_mask);
		end
	end

endmodule : terminal_decoder

/* tb/contact_bank.sv */
// Purpose: Operator contacts wired to the decoder input terminals.
// Assumes: Contacts change on the control clock and do not bounce.
// Notes:   The run contact opens while the fault reset contact is closed.
`timescale 1ns/1ps
module contact_bank #(
	parameter int RESET_BIT = 4 // Terminal that carries fault reset
) (
	input  wire logic       i_clock,    // Control clock
	input  wire logic [5:0] i_closed,   // Contacts asked closed
	input  wire logic       i_run_req,  // Run contact asked closed
	output logic      [5:0] o_terminal, // Terminal levels, 1 shorted
	output logic            o_run       // Run command level
);
	// Contacts settle one clock after the request
	always_ff @(posedge i_clock) begin
		o_terminal <= i_closed;
		o_run      <= i_run_req && !i_closed[RESET_BIT];
	end
endmodule : contact_bank

/* tb/terminal_decoder_properties.sv */
// Purpose: Concurrent checks on the decoder ports.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached by bind after the module.
`timescale 1ns/1ps
module terminal_decoder_properties (
	input wire logic        i_clock,          // Clock
	input wire logic        i_reset,          // Reset
	input wire logic        i_read,           // Bus read
	input wire logic        i_write,          // Bus write
	input wire logic        o_waitrequest,    // Bus wait
	input wire logic [15:0] i_current_value,  // Current input
	input wire logic        i_fault_active,   // Fault present
	input wire logic        i_stop_reset_key, // Stop key
	input wire logic        i_running,        // Drive running
	input wire logic        o_use_current,    // Current chosen
	input wire logic [15:0] o_analog_freq,    // Analog value
	input wire logic        o_fault_clear,    // Clear pulse
	input wire logic        o_comm_error,     // Error shown
	input wire logic [1:0]  o_cmd_source      // Active source
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// Bus answers after a taken request, for one cycle only
	a_wait_taken:
		assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("Request not taken");
	a_wait_single:
		assert property (!o_waitrequest |=> o_waitrequest) else $error("Wait low too long");
	a_wait_cause:
		assert property (!o_waitrequest |-> $past(i_read || i_write)) else $error("Answer without request");
	// Fault clear is a single pulse caused by a present fault
	a_clear_pulse:
		assert property (o_fault_clear |=> !o_fault_clear) else $error("Fault clear too long");
	a_clear_cause:
		assert property (o_fault_clear |-> $past(i_fault_active)) else $error("Fault clear without fault");
	// Stop key ends the error display
	a_error_stop:
		assert property (i_stop_reset_key |=> !o_comm_error) else $error("Error kept after stop key");
	// Current input passes through when selected
	a_current_pass:
		assert property (o_use_current && $past(o_use_current) && $past(i_current_value) == $past(i_current_value, 2)
			|-> o_analog_freq == $past(i_current_value)) else $error("Current value not passed");
	// Source changes only once the drive has stopped
	a_source_idle:
		assert property (!$stable(o_cmd_source) |-> !$past(i_running)) else $error("Source changed while running");
endmodule : terminal_decoder_properties

bind terminal_decoder terminal_decoder_properties u_props (.i_clock, .i_reset, .i_read, .i_write, .o_waitrequest,
	.i_current_value, .i_fault_active, .i_stop_reset_key, .i_running, .o_use_current, .o_analog_freq,
	.o_fault_clear, .o_comm_error, .o_cmd_source);

/* tb/terminal_decoder_tb_top.sv */
// Purpose: Self-checking bench for the terminal decoder.
// Assumes: Shortened hold and tenth-second counts keep the run brief.
// Notes:   Table rows cover single-terminal functions; hand tests follow.
`timescale 1ns/1ps
module terminal_decoder_tb_top;
	import terminal_decoder_pkg::*;
	localparam int HOLD = 20; // Shortened reset hold limit
	typedef struct packed {
		logic [4:0] code; // Function code of terminal 0
		logic       pol;  // Polarity bit
		logic       lvl;  // Contact closed
		logic [1:0] mode; // PID mode
		logic [7:0] exp;  // Expected status bits 7:0
	} row_t;
	logic        i_clock = 1'b0, i_reset = 1'b1, i_read = 1'b0, i_write = 1'b0; // Clock, reset, bus strobes
	logic [7:0]  i_address = 8'h00;                  // Bus address
	logic [31:0] i_writedata = 32'h0, o_readdata, rd; // Bus data and last read
	logic [15:0] i_voltage_value = 16'h0064, i_current_value = 16'h0032, o_analog_freq, o_updown_freq;
	logic        i_fault_active = 1'b0, i_stop_reset_key = 1'b0, i_running = 1'b0; // Drive state
	logic [5:0]  closed = 6'h00, i_terminal;         // Contacts asked and seen
	logic        run_req = 1'b0, i_run_command, o_waitrequest, o_irq, irq_hi; // Run, bus wait, interrupt
	logic        o_use_current, o_fault_clear, o_comm_error, o_three_wire_run, o_reverse;
	logic        o_override_stop, o_integral_clear, o_pid_bypass;
	logic [1:0]  o_cmd_source;                       // Active source
	int          bad_count = 0, compares = 0, cycles = 0, seen; // Counters
	row_t        rows [8];                           // Ordinary cases
	wire logic [7:0] obs = {o_pid_bypass, o_integral_clear, o_override_stop, o_reverse, o_three_wire_run,
		o_comm_error, o_fault_clear, o_use_current}; // Status bits 7:0 as ports
	// Clock and the bounded run
	always #20 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			stop_test();
		end
	end
	terminal_decoder #(.HOLD_CYCLES(HOLD), .TENTH_CYCLES(2)) DUT (.*);
	contact_bank #(.RESET_BIT(4)) u_contacts (.i_clock(i_clock), .i_closed(closed), .i_run_req(run_req),
		.o_terminal(i_terminal), .o_run(i_run_command));
	// One bus access, held until wait is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= d;
		i_write <= wr;
		i_read <= !wr;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		q = o_readdata;
		if (n >= 50) bad_count++;
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_clock);
	endtask : bus
	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	initial begin
		rows = '{'{FN_ANALOG_SELECT, 1'b0, 1'b1, 2'h0, 8'h01}, '{FN_ANALOG_SELECT, 1'b0, 1'b0, 2'h0, 8'h00},
			'{FN_ANALOG_SELECT, 1'b1, 1'b0, 2'h0, 8'h01}, '{FN_THREE_DIR, 1'b0, 1'b1, 2'h0, 8'h10},
			'{FN_INTEGRAL_CLR, 1'b0, 1'b1, PID_MODE_PID, 8'h40}, '{FN_INTEGRAL_CLR, 1'b0, 1'b1, 2'h0, 8'h00},
			'{FN_PID_BYPASS, 1'b0, 1'b1, PID_MODE_FEED, 8'h80}, '{FN_PID_BYPASS, 1'b0, 1'b1, 2'h3, 8'h00}};
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		@(posedge i_clock);
		// Reset values and an unmapped place
		bus(1'b0, ADDR_MAX_FREQ, 32'h0, rd);
		chk(rd, 32'h0000_1770);
		bus(1'b0, ADDR_RAMP_TIME, 32'h0, rd);
		chk(rd, 32'h0000_0064);
		bus(1'b0, 8'h80, 32'h0, rd);
		chk(rd, 32'h0);
		foreach (rows[k]) begin
			closed <= 6'h00;
			bus(1'b1, ADDR_FUNC_BASE, {27'h0, rows[k].code}, rd);
			bus(1'b1, ADDR_POLARITY, {31'h0, rows[k].pol}, rd);
			bus(1'b1, ADDR_PID_MODE, {30'h0, rows[k].mode}, rd);
			closed <= {5'h00, rows[k].lvl};
			repeat (4) @(posedge i_clock);
			chk(obs, rows[k].exp);
		end
		// Sum of both inputs with no select terminal
		bus(1'b1, ADDR_FREQ_SOURCE, {30'h0, FREQ_SRC_TERMINAL}, rd);
		repeat (4) @(posedge i_clock);
		chk(o_analog_freq, 16'h0096);
		// Fault reset held past the limit, with interrupts
		bus(1'b1, ADDR_FUNC_BASE + 8'h10, {27'h0, FN_FAULT_RESET}, rd);
		bus(1'b1, ADDR_IRQ_MASK, 32'h7, rd);
		i_fault_active <= 1'b1;
		closed <= 6'h10;
		seen = 0;
		repeat (8) begin
			@(posedge i_clock);
			if (o_fault_clear === 1'b1) seen++;
		end
		chk(seen, 1);
		repeat (HOLD + 4) @(posedge i_clock);
		chk(o_comm_error, 1'b1);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk(rd[23:16], COMM_ERROR_CODE);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0, rd);
		chk(rd[2:0], 3'h3);
		irq_hi = o_irq;
		bus(1'b1, ADDR_IRQ_MASK, 32'h0, rd);
		repeat (2) @(posedge i_clock);
		chk(irq_hi ^ o_irq, 1'b1);
		bus(1'b1, ADDR_IRQ_STATUS, 32'h7, rd);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0, rd);
		chk(rd, 32'h0);
		chk(o_irq, 1'b0);
		i_stop_reset_key <= 1'b1;
		repeat (3) @(posedge i_clock);
		chk(o_comm_error, 1'b0);
		i_stop_reset_key <= 1'b0;
		closed <= 6'h00;
		i_fault_active <= 1'b0;
		// Up and down with saturation at both ends
		bus(1'b1, ADDR_FUNC_BASE, {27'h0, FN_UP}, rd);
		bus(1'b1, ADDR_FUNC_BASE + 8'h04, {27'h0, FN_DOWN}, rd);
		bus(1'b1, ADDR_MAX_FREQ, 32'h5, rd);
		bus(1'b1, ADDR_RAMP_TIME, 32'h1, rd);
		bus(1'b1, ADDR_INITIAL, 32'h3, rd);
		run_req <= 1'b1;
		i_running <= 1'b1;
		repeat (4) @(posedge i_clock);
		chk(o_updown_freq, 16'h0003);
		closed <= 6'h01;
		repeat (40) @(posedge i_clock);
		chk(o_updown_freq, 16'h0005);
		closed <= 6'h02;
		repeat (40) @(posedge i_clock);
		chk(o_updown_freq, 16'h0000);
		// Overrides while running, then after the stop
		closed <= 6'h00;
		bus(1'b1, ADDR_FUNC_BASE + 8'h08, {27'h0, FN_KEYPAD_OVR}, rd);
		bus(1'b1, ADDR_FUNC_BASE + 8'h0C, {27'h0, FN_TERMINAL_OVR}, rd);
		closed <= 6'h0C;
		repeat (4) @(posedge i_clock);
		chk(o_override_stop, 1'b1);
		chk(o_cmd_source, SRC_CONFIGURED);
		// Save enabled: the reference at run fall becomes the initial value
		bus(1'b1, ADDR_SAVE_ENABLE, 32'h1, rd);
		i_running <= 1'b0;
		run_req <= 1'b0;
		repeat (4) @(posedge i_clock);
		chk(o_cmd_source, SRC_KEYPAD);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0, rd);
		chk(rd[2], 1'b1);
		bus(1'b0, ADDR_INITIAL, 32'h0, rd);
		chk(rd, 32'h0);
		closed <= 6'h08;
		repeat (4) @(posedge i_clock);
		chk(o_cmd_source, SRC_TERMINAL);
		// Three-wire start latches under keep and drops when keep opens
		bus(1'b1, ADDR_FUNC_BASE, {27'h0, FN_THREE_START}, rd);
		bus(1'b1, ADDR_FUNC_BASE + 8'h04, {27'h0, FN_THREE_KEEP}, rd);
		closed <= 6'h03;
		repeat (4) @(posedge i_clock);
		closed <= 6'h02;
		repeat (4) @(posedge i_clock);
		chk(o_three_wire_run, 1'b1);
		closed <= 6'h01;
		repeat (4) @(posedge i_clock);
		chk(o_three_wire_run, 1'b0);
		stop_test();
	end
endmodule : terminal_decoder_tb_top
